// file: pkg/scp_pkg.sv
package scp_pkg;
  // Clock and link timing
  localparam int CLK_HZ        = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int LINK_BAUD     = 38400;
  localparam int BAUD_DIV_DEF  = CLK_HZ / LINK_BAUD;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

  // Command byte layout
  localparam int CMD_DIR_BIT = 7;
  localparam int CMD_FN_MSB  = 6;
  localparam int CMD_FN_LSB  = 5;
  localparam int CMD_PD_BIT  = 4;
  localparam int CMD_LEN_MSB = 3;
  localparam logic [1:0]  FN_SETPOINT  = 2'h0;
  localparam logic [3:0]  LEN_SETPOINT = 4'h3;
  localparam logic [15:0] SETPOINT_MAX = 16'h2710;
  localparam logic [2:0]  FRAME_LAST   = 3'h4;

  // Reply and text answers
  localparam logic [7:0] REPLY_HDR   = 8'h89;
  localparam logic [3:0] REPLY_LAST  = 4'h9;
  localparam logic [3:0] ACK_LAST    = 4'h2;
  localparam logic [3:0] REPORT_LAST = 4'ha;
  localparam logic [3:0] DIGIT_FIRST = 4'h4;
  localparam logic [3:0] DIGIT_LAST  = 4'h8;

  // Characters
  localparam logic [7:0] CH_A    = 8'h41;
  localparam logic [7:0] CH_D    = 8'h44;
  localparam logic [7:0] CH_I    = 8'h49;
  localparam logic [7:0] CH_P    = 8'h50;
  localparam logic [7:0] CH_R    = 8'h52;
  localparam logic [7:0] CH_S    = 8'h53;
  localparam logic [7:0] CH_Z    = 8'h5a;
  localparam logic [7:0] CH_0    = 8'h30;
  localparam logic [7:0] CH_9    = 8'h39;
  localparam logic [7:0] CH_SP   = 8'h20;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_CR   = 8'h0d;
  localparam logic [7:0] CH_LF   = 8'h0a;
  localparam logic [23:0] NAME_SETPOINT = {CH_S, CH_S, CH_P};
  localparam logic [23:0] NAME_REPORT   = {CH_S, CH_A, CH_I};

  typedef enum logic [1:0] {
    TX_NONE   = 2'b00,
    TX_REPLY  = 2'b01,
    TX_ACK    = 2'b10,
    TX_REPORT = 2'b11
  } tx_kind_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_e;
endpackage

// file: src/serial_uart.sv
`timescale 1ns/1ps
module serial_uart import scp_pkg::*; #(
  parameter int BAUD_DIV = BAUD_DIV_DEF
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Serial pins
  input  wire logic       rxd,
  output logic            txd,
  // Received bytes
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  // Bytes to send
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  localparam logic [15:0] BIT_TOP  = 16'(BAUD_DIV - 1);
  localparam logic [15:0] HALF_TOP = 16'(BAUD_DIV / 2 - 1);
  localparam logic [2:0]  RX_LAST  = 3'h7;
  localparam logic [3:0]  TX_LAST  = 4'h9;

  typedef struct packed {
    rx_state_e   rx_st;
    logic [15:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_valid;
    logic        tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
  } uart_s;

  uart_s st_r, st_nxt;

  assign txd      = st_r.tx_sh[0];
  assign rx_valid = st_r.rx_valid;
  assign rx_data  = st_r.rx_sh;
  assign tx_ready = !st_r.tx_busy;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_valid = 1'b0;
    st_nxt.rx_cnt = st_r.rx_cnt + 16'h1;
    // 8N1 framing, LSB first, one bit per BAUD_DIV cycles
    case (st_r.rx_st)
      RX_IDLE: begin
        st_nxt.rx_cnt = 16'h0;
        if (!rxd) st_nxt.rx_st = RX_START;
      end
      RX_START: begin
        if (st_r.rx_cnt == HALF_TOP) begin
          st_nxt.rx_cnt = 16'h0;
          st_nxt.rx_bit = 3'h0;
          // A glitch shorter than half a bit is not a start bit
          st_nxt.rx_st  = rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (st_r.rx_cnt == BIT_TOP) begin
          st_nxt.rx_cnt = 16'h0;
          st_nxt.rx_sh  = {rxd, st_r.rx_sh[7:1]};
          st_nxt.rx_bit = st_r.rx_bit + 3'h1;
          if (st_r.rx_bit == RX_LAST) st_nxt.rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (st_r.rx_cnt == BIT_TOP) begin
          // A missing stop bit drops the byte
          st_nxt.rx_valid = rxd;
          st_nxt.rx_st    = RX_IDLE;
        end
      end
      default: st_nxt.rx_st = RX_IDLE;
    endcase

    if (!st_r.tx_busy) begin
      if (tx_valid) begin
        st_nxt.tx_busy = 1'b1;
        st_nxt.tx_cnt  = 16'h0;
        st_nxt.tx_bit  = 4'h0;
        st_nxt.tx_sh   = {1'b1, tx_data, 1'b0};
      end
    end else if (st_r.tx_cnt == BIT_TOP) begin
      st_nxt.tx_cnt = 16'h0;
      st_nxt.tx_sh  = {1'b1, st_r.tx_sh[9:1]};
      st_nxt.tx_bit = st_r.tx_bit + 4'h1;
      if (st_r.tx_bit == TX_LAST) st_nxt.tx_busy = 1'b0;
    end else begin
      st_nxt.tx_cnt = st_r.tx_cnt + 16'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.tx_sh <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// file: src/serial_setpoint_port.sv
`timescale 1ns/1ps
// What this block does
// - Binary link runs at 38400 baud on both ends.
// - Address byte content is ignored.
// - Bits 6:5 zero mean setpoint, bit 4 zero means process data.
// - Bits 3:0 count following bytes, three for a setpoint write.
// - Setpoint 0 to 10000 maps to 0 to 100.00 percent.
// - Checksum is command plus both data bytes modulo 256.
// - Reply is 0x89, four 16-bit values, then a checksum.
// - Text link uses 38400 baud, 8 data bits, no parity, 1 stop.
// - Setpoint text command in range updates setpoint and acknowledges.
// - Auto-report 1000 sends a feedback line every second.
// - Auto-report 0 stops the periodic feedback lines.
module serial_setpoint_port import scp_pkg::*; #(
  parameter int BAUD_DIV  = BAUD_DIV_DEF,
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Serial pins
  input  wire logic        rxd,
  output logic             txd,
  // Link selection: 0 binary frames, 1 text commands
  input  wire logic        ascii_mode,
  // Values reported to the host
  input  wire logic [15:0] feedback,
  input  wire logic [15:0] analog_in,
  input  wire logic [15:0] rel_pressure,
  input  wire logic [15:0] free_var9,
  // Controller side
  output logic [15:0]      setpoint,
  output logic             setpoint_strobe,
  output logic             report_on
);
  localparam logic [31:0] MS_TOP = 32'(MS_CYCLES - 1);
  typedef struct packed {
    logic [2:0]  fr_idx;
    logic [7:0]  fr_cmd;
    logic [7:0]  fr_lsb;
    logic [7:0]  fr_msb;
    logic [23:0] name;
    logic [16:0] acc;
    logic        acc_any;
    logic        acc_bad;
    logic [15:0] setpoint;
    logic        sp_strobe;
    logic        report_on;
    logic [13:0] rep_ms;
    logic [31:0] ms_cnt;
    logic [13:0] ms_n;
    logic        reply_due;
    logic        ack_due;
    logic        report_due;
    tx_kind_e    kind;
    logic [3:0]  tx_idx;
    logic        tx_go;
    logic [7:0]  tx_byte;
    logic [63:0] snap;
  } port_s;

  port_s       st_r, st_nxt;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_ready;
  logic [15:0] fr_val;
  logic [7:0]  fr_sum;
  logic        frame_end, frame_good, is_digit, txt_eol;
  logic        txt_sp_ok, txt_rep_ok;
  logic [20:0] acc_next;

  serial_uart #(.BAUD_DIV(BAUD_DIV)) serial_uart_i (
    .mclk(mclk), .rstn(rstn), .rxd(rxd), .txd(txd),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
    .tx_valid(st_r.tx_go), .tx_data(st_r.tx_byte)
  );

  function automatic logic [7:0] reply_sum(input logic [63:0] s);
    logic [7:0] a;
    a = 8'h0;
    for (int i = 0; i < 8; i++) a = a + s[8*i +: 8];
    return a;
  endfunction
  // Decimal digit, pos 4 is ten-thousands down to pos 0 units
  function automatic logic [7:0] dec_digit(input logic [15:0] v,
                                           input logic [3:0]  pos);
    logic [15:0] q;
    q = pos == 4'h4 ? v / 16'd10000 : pos == 4'h3 ? v / 16'd1000
      : pos == 4'h2 ? v / 16'd100 : pos == 4'h1 ? v / 16'd10 : v;
    return CH_0 + 8'(q % 16'd10);
  endfunction
  function automatic logic [3:0] last_idx(input tx_kind_e k);
    return k == TX_REPLY ? REPLY_LAST : k == TX_ACK ? ACK_LAST : REPORT_LAST;
  endfunction
  function automatic logic [7:0] byte_at(input tx_kind_e k,
                                         input logic [3:0] i,
                                         input logic [63:0] s);
    if (k == TX_REPLY)
      return i == 4'h0 ? REPLY_HDR : i == REPLY_LAST ? reply_sum(s)
             : 8'(s >> {i - 4'h1, 3'h0});
    if (k == TX_ACK)
      return i == 4'h0 ? CH_A : i == 4'h1 ? CH_BANG : CH_CR;
    case (i)
      4'h0:    return CH_A;
      4'h1:    return CH_D;
      4'h2:    return CH_R;
      4'h3:    return CH_SP;
      4'h9:    return CH_CR;
      4'ha:    return CH_LF;
      default: return dec_digit(s[15:0], DIGIT_LAST - i);
    endcase
  endfunction

  assign fr_val    = {st_r.fr_msb, st_r.fr_lsb};
  assign fr_sum    = st_r.fr_cmd + st_r.fr_lsb + st_r.fr_msb;
  assign frame_end = rx_valid && !ascii_mode && st_r.fr_idx == FRAME_LAST;
  assign frame_good = !st_r.fr_cmd[CMD_DIR_BIT]
    && st_r.fr_cmd[CMD_FN_MSB:CMD_FN_LSB] == FN_SETPOINT
    && !st_r.fr_cmd[CMD_PD_BIT]
    && st_r.fr_cmd[CMD_LEN_MSB:0] == LEN_SETPOINT
    && rx_data == fr_sum
    && fr_val <= SETPOINT_MAX;
  assign is_digit   = rx_data >= CH_0 && rx_data <= CH_9;
  assign acc_next   = 21'(st_r.acc * 17'd10) + 21'(rx_data - CH_0);
  assign txt_eol    = rx_valid && ascii_mode
                      && (rx_data == CH_CR || rx_data == CH_LF);
  assign txt_sp_ok  = txt_eol && st_r.name == NAME_SETPOINT
                      && st_r.acc_any && !st_r.acc_bad;
  assign txt_rep_ok = txt_eol && st_r.name == NAME_REPORT
                      && st_r.acc_any && !st_r.acc_bad;
  assign setpoint        = st_r.setpoint;
  assign setpoint_strobe = st_r.sp_strobe;
  assign report_on       = st_r.report_on;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sp_strobe = 1'b0;
    // Transmit sequencer; launch clears first so a new event set wins
    if (st_r.kind == TX_NONE) begin
      st_nxt.tx_idx = 4'h0;
      st_nxt.snap   = {free_var9, rel_pressure, analog_in, feedback};
      if (st_r.reply_due) begin
        st_nxt.kind = TX_REPLY;
        st_nxt.reply_due = 1'b0;
      end else if (st_r.ack_due) begin
        st_nxt.kind = TX_ACK;
        st_nxt.ack_due = 1'b0;
      end else if (st_r.report_due) begin
        st_nxt.kind = TX_REPORT;
        st_nxt.report_due = 1'b0;
      end
    end else if (!st_r.tx_go) begin
      st_nxt.tx_go   = 1'b1;
      st_nxt.tx_byte = byte_at(st_r.kind, st_r.tx_idx, st_r.snap);
    end else if (tx_ready) begin
      st_nxt.tx_go  = 1'b0;
      st_nxt.tx_idx = st_r.tx_idx + 4'h1;
      if (st_r.tx_idx == last_idx(st_r.kind)) st_nxt.kind = TX_NONE;
    end
    // Binary frame: no idle timeout, so a lost byte shifts framing
    if (rx_valid && !ascii_mode) begin
      st_nxt.fr_idx = st_r.fr_idx + 3'h1;
      case (st_r.fr_idx)
        3'h0:    ;
        3'h1:    st_nxt.fr_cmd = rx_data;
        3'h2:    st_nxt.fr_lsb = rx_data;
        3'h3:    st_nxt.fr_msb = rx_data;
        default: begin
          st_nxt.fr_idx = 3'h0;
          if (frame_good) begin
            st_nxt.setpoint  = fr_val;
            st_nxt.sp_strobe = 1'b1;
            st_nxt.reply_due = 1'b1;
          end
        end
      endcase
    end
    // Periodic report timer, period in milliseconds
    if (st_r.report_on) begin
      st_nxt.ms_cnt = st_r.ms_cnt + 32'h1;
      if (st_r.ms_cnt == MS_TOP) begin
        st_nxt.ms_cnt = 32'h0;
        st_nxt.ms_n   = st_r.ms_n + 14'h1;
        if (st_r.ms_n + 14'h1 == st_r.rep_ms) begin
          st_nxt.ms_n = 14'h0;
          st_nxt.report_due = 1'b1;
        end
      end
    end
    // Text commands: name letters, then a decimal argument, then EOL
    if (rx_valid && ascii_mode) begin
      if (rx_data >= CH_A && rx_data <= CH_Z) begin
        st_nxt.name    = {st_r.name[15:0], rx_data};
        st_nxt.acc     = 17'h0;
        st_nxt.acc_any = 1'b0;
        st_nxt.acc_bad = 1'b0;
      end else if (is_digit) begin
        st_nxt.acc_any = 1'b1;
        if (acc_next > 21'(SETPOINT_MAX)) st_nxt.acc_bad = 1'b1;
        else if (!st_r.acc_bad) st_nxt.acc = 17'(acc_next);
      end else if (txt_eol) begin
        st_nxt.name = 24'h0;
        st_nxt.acc  = 17'h0;
        st_nxt.acc_any = 1'b0;
        st_nxt.acc_bad = 1'b0;
        if (txt_sp_ok) begin
          st_nxt.setpoint  = st_r.acc[15:0];
          st_nxt.sp_strobe = 1'b1;
          st_nxt.ack_due   = 1'b1;
        end
        if (txt_rep_ok) begin
          st_nxt.report_on = st_r.acc != 17'h0;
          st_nxt.rep_ms    = st_r.acc[13:0];
          st_nxt.ms_cnt    = 32'h0;
          st_nxt.ms_n      = 14'h0;
          if (st_r.acc == 17'h0) st_nxt.report_due = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) st_r <= '0;
    else st_r <= st_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_frame_end;
    frame_end;
  endsequence
  property p_frame_good;
    s_frame_end ##0 frame_good |=>
      setpoint == $past(fr_val) && setpoint_strobe && st_r.reply_due;
  endproperty
  a_frame_good: assert property (p_frame_good)
    else $error("good frame did not load setpoint");
  property p_bad_sum;
    s_frame_end ##0 (rx_data != 8'(st_r.fr_cmd + st_r.fr_lsb + st_r.fr_msb))
      |=> $stable(setpoint) && !setpoint_strobe;
  endproperty
  a_bad_sum: assert property (p_bad_sum)
    else $error("frame with bad checksum changed setpoint");
  property p_bad_field;
    s_frame_end ##0 (st_r.fr_cmd[CMD_LEN_MSB:0] != LEN_SETPOINT
      || st_r.fr_cmd[CMD_FN_MSB:CMD_PD_BIT] != 3'h0
      || fr_val > SETPOINT_MAX) |=> !setpoint_strobe && !st_r.reply_due;
  endproperty
  a_bad_field: assert property (p_bad_field)
    else $error("frame with bad field was accepted");
  property p_addr_ignored;
    rx_valid && !ascii_mode && st_r.fr_idx == 3'h0 |=> st_r.fr_idx == 3'h1;
  endproperty
  a_addr_ignored: assert property (p_addr_ignored)
    else $error("address byte not skipped");
  sequence s_reply_start;
    st_r.tx_go && st_r.kind == TX_REPLY && st_r.tx_idx == 4'h0;
  endsequence
  property p_reply_hdr;
    s_reply_start |-> st_r.tx_byte == REPLY_HDR;
  endproperty
  a_reply_hdr: assert property (p_reply_hdr)
    else $error("reply does not open with header byte");
  // Summed from the snapshot, so inputs may move while a reply is sent
  property p_reply_sum;
    st_r.tx_go && st_r.kind == TX_REPLY && st_r.tx_idx == REPLY_LAST |->
      st_r.tx_byte == 8'(st_r.snap[7:0] + st_r.snap[15:8] + st_r.snap[23:16]
        + st_r.snap[31:24] + st_r.snap[39:32] + st_r.snap[47:40]
        + st_r.snap[55:48] + st_r.snap[63:56]);
  endproperty
  a_reply_sum: assert property (p_reply_sum)
    else $error("reply checksum wrong");
  property p_text_setpoint;
    txt_sp_ok |=> setpoint == $past(st_r.acc[15:0]) && st_r.ack_due;
  endproperty
  a_text_setpoint: assert property (p_text_setpoint)
    else $error("text setpoint not applied or not acknowledged");
  property p_report_tick;
    st_r.report_on && st_r.ms_cnt == MS_TOP
      && st_r.ms_n + 14'h1 == st_r.rep_ms |=> st_r.report_due;
  endproperty
  a_report_tick: assert property (p_report_tick)
    else $error("report period elapsed without report");
  property p_report_off;
    txt_rep_ok && st_r.acc == 17'h0 |=>
      !report_on && !st_r.report_due ##1 st_r.kind != TX_REPORT
        || $past(st_r.kind) == TX_REPORT;
  endproperty
  a_report_off: assert property (p_report_off)
    else $error("auto report not stopped");
endmodule

// file: bench/serial_host.sv
`timescale 1ns/1ps
// Host at the far end of the serial link: sends request bytes, collects replies
module serial_host #(
  parameter int BAUD_DIV = 8
) (
  input  wire logic mclk,
  output logic      rxd,
  input  wire logic txd
);
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;
  int         frame_err = 0;

  // Line rests high between bytes, as an idle UART does
  initial rxd = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      rxd = f[i];
      repeat (BAUD_DIV - 1) @(negedge mclk);
    end
  endtask

  // Mid-bit sampling; a low stop bit is counted as a framing fault
  always begin
    @(negedge txd);
    repeat (BAUD_DIV / 2) @(posedge mclk);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(posedge mclk);
        rx_b[i] = txd;
      end
      repeat (BAUD_DIV) @(posedge mclk);
      if (txd !== 1'b1) frame_err++;
      rx_q.push_back(rx_b);
    end
  end
endmodule

// file: bench/serial_setpoint_port_bench.sv
`timescale 1ns/1ps
module serial_setpoint_port_bench;
  import scp_pkg::*;
  localparam int BD = 8;
  localparam int MS = 20;
  typedef logic [7:0] bq_t[$];

  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        rxd;
  logic        txd;
  logic        ascii_mode = 1'b0;
  logic [15:0] feedback = 16'd3333;
  logic [15:0] analog_in = 16'h1a2b;
  logic [15:0] rel_pressure = 16'h00ff;
  logic [15:0] free_var9 = 16'hc3d4;
  logic [15:0] setpoint;
  logic        setpoint_strobe;
  logic        report_on;
  int          fails = 0;
  int          checked = 0;
  int          strobes = 0;

  always #2.5 mclk = ~mclk;

  serial_setpoint_port #(.BAUD_DIV(BD), .MS_CYCLES(MS)) serial_setpoint_port_i (
    .mclk(mclk), .rstn(rstn), .rxd(rxd), .txd(txd), .ascii_mode(ascii_mode),
    .feedback(feedback), .analog_in(analog_in), .rel_pressure(rel_pressure),
    .free_var9(free_var9), .setpoint(setpoint),
    .setpoint_strobe(setpoint_strobe), .report_on(report_on)
  );

  serial_host #(.BAUD_DIV(BD)) serial_host_i (
    .mclk(mclk), .rxd(rxd), .txd(txd)
  );

  // A pulse longer than one cycle shows up as extra counts
  always @(posedge mclk) if (setpoint_strobe === 1'b1) strobes++;

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_bytes(input int n, input int limit);
    int k;
    k = 0;
    while (serial_host_i.rx_q.size() < n && k < limit) begin
      @(posedge mclk);
      k++;
    end
  endtask

  task automatic expect_q(input bq_t e, input int limit);
    wait_bytes(e.size(), limit);
    check("byte count", 16'(serial_host_i.rx_q.size()), 16'(e.size()));
    while (e.size() > 0 && serial_host_i.rx_q.size() > 0)
      check("byte", {8'h00, serial_host_i.rx_q.pop_front()},
            {8'h00, e.pop_front()});
  endtask

  function automatic bq_t str_q(input string s);
    bq_t q;
    foreach (s[i]) q.push_back(s[i]);
    return q;
  endfunction

  // Checksum covers the eight value bytes, header left out
  function automatic bq_t reply_q();
    bq_t q;
    logic [7:0] s;
    q = {8'h89, feedback[7:0], feedback[15:8], analog_in[7:0],
         analog_in[15:8], rel_pressure[7:0], rel_pressure[15:8],
         free_var9[7:0], free_var9[15:8]};
    s = 8'h00;
    foreach (q[i]) if (i > 0) s = s + q[i];
    q.push_back(s);
    return q;
  endfunction

  task automatic send_frame(input logic [7:0] cmd, input logic [15:0] v,
                            input logic [7:0] skew);
    serial_host_i.send_byte(8'h5a);
    serial_host_i.send_byte(cmd);
    serial_host_i.send_byte(v[7:0]);
    serial_host_i.send_byte(v[15:8]);
    serial_host_i.send_byte(8'(cmd + v[7:0] + v[15:8] + skew));
  endtask

  // Command name from the package, then the argument text
  task automatic send_cmd(input logic [23:0] nm, input string arg);
    for (int i = 2; i >= 0; i--) serial_host_i.send_byte(nm[8*i +: 8]);
    foreach (arg[i]) serial_host_i.send_byte(arg[i]);
  endtask

  task automatic t_reset();
    check("setpoint", setpoint, 16'h0000);
    check("report_on", {15'h0, report_on}, 16'h0000);
    check("txd", {15'h0, txd}, 16'h0001);
  endtask

  task automatic t_bin_ok();
    send_frame(8'h03, 16'd5000, 8'h00);
    expect_q(reply_q(), 2000);
    check("setpoint", setpoint, 16'd5000);
    check("strobes", 16'(strobes), 16'h0001);
    send_frame(8'h03, 16'd10000, 8'h00);
    expect_q(reply_q(), 2000);
    check("setpoint", setpoint, 16'd10000);
    check("strobes", 16'(strobes), 16'h0002);
  endtask

  // Wrong direction, function, data kind, length, checksum, range
  task automatic t_bin_bad();
    logic [7:0]  cmds[7] = '{8'h83, 8'h23, 8'h43, 8'h13, 8'h04, 8'h03, 8'h03};
    logic [15:0] vals[7] = '{16'd5000, 16'd5000, 16'd5000, 16'd5000,
                             16'd5000, 16'd5000, 16'd10001};
    logic [7:0]  skew[7] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h0};
    int s0;
    s0 = strobes;
    for (int i = 0; i < 7; i++) begin
      send_frame(cmds[i], vals[i], skew[i]);
      repeat (150) @(posedge mclk);
      check("reply bytes", 16'(serial_host_i.rx_q.size()), 16'h0000);
      check("setpoint", setpoint, 16'd10000);
      check("strobes", 16'(strobes), 16'(s0));
    end
  endtask

  task automatic t_text();
    int s0;
    @(negedge mclk);
    ascii_mode = 1'b1;
    send_cmd(NAME_SETPOINT, " 1234\015");
    expect_q(str_q("A!\015"), 2000);
    check("setpoint", setpoint, 16'd1234);
    check("strobes", 16'(strobes), 16'h0003);
    s0 = strobes;
    send_cmd(NAME_SETPOINT, " 10001\015");
    send_cmd(NAME_SETPOINT, "\015");
    repeat (300) @(posedge mclk);
    check("reply bytes", 16'(serial_host_i.rx_q.size()), 16'h0000);
    check("setpoint", setpoint, 16'd1234);
    check("strobes", 16'(strobes), 16'(s0));
  endtask

  // Period is 1000 ms of MS cycles each; gap runs end of one line to next
  task automatic t_report();
    int k;
    send_cmd(NAME_REPORT, " 1000\015");
    repeat (4) @(posedge mclk);
    check("report_on", {15'h0, report_on}, 16'h0001);
    expect_q(str_q("ADR 03333\015\n"), 22000);
    k = 0;
    while (serial_host_i.rx_q.size() == 0 && k < 22000) begin
      @(posedge mclk);
      k++;
    end
    check("period", {15'h0, k > 18500 && k < 20500}, 16'h0001);
    expect_q(str_q("ADR 03333\015\n"), 2000);
    send_cmd(NAME_REPORT, " 0\015");
    repeat (4) @(posedge mclk);
    check("report_on", {15'h0, report_on}, 16'h0000);
    repeat (21000) @(posedge mclk);
    check("report bytes", 16'(serial_host_i.rx_q.size()), 16'h0000);
  endtask

  initial begin
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    t_reset();
    t_bin_ok();
    t_bin_bad();
    t_text();
    t_report();
    check("framing", 16'(serial_host_i.frame_err), 16'h0000);
    test_done();
  end

  // Whole run needs about 72000 cycles
  initial begin
    repeat (95000) @(posedge mclk);
    fails++;
    test_done();
  end
endmodule
